//--- ddbb_pkg.sv
// Constants and types of the diagnostic block builder
package ddbb_pkg;
  // Section lengths
  localparam logic [6:0] STD_LEN = 7'h06;
  localparam logic [6:0] MOD_LEN = 7'h09;
  localparam logic [6:0] DEV_LEN = 7'h07;
  localparam logic [6:0] STATIC_LEN = 7'h16;
  localparam logic [6:0] MAX_LEN = 7'h40;
  localparam logic [6:0] CH_LEN = 7'h03;
  localparam logic [6:0] PS_LEN = 7'h05;
  // Byte positions in the block
  localparam logic [5:0] MOD_HDR_POS = 6'h06;
  localparam logic [5:0] BMP_POS = 6'h07;
  localparam logic [5:0] DEV_POS = 6'h0F;
  // Fixed header and field values
  localparam logic [7:0] MOD_HDR = 8'h49;
  localparam logic [7:0] DEV_HDR = 8'h07;
  localparam logic [7:0] DEV_TYPE = 8'h81;
  localparam logic [7:0] PS_HDR = 8'h05;
  localparam logic [7:0] PS_TYPE = 8'h81;
  localparam logic [7:0] PS_DIFF = 8'h00;
  localparam logic [7:0] PS_ERR_BASE = 8'h40;
  localparam logic [1:0] CH_TAG = 2'h2;
  localparam logic [1:0] CH_IO_TYPE = 2'h1;
  localparam logic [5:0] CH_MODULE_ID = 6'h3F;
  localparam logic [7:0] CH_ERR = 8'h29;
  // Standard diagnostic fields
  localparam int EXT_DIAG_BIT = 3;
  localparam logic [7:0] STD1_FIXED = 8'h04;
  localparam int OVF_BIT = 7;
  // Module status byte fields
  localparam int ST_PEND_BIT = 7;
  localparam int ST_PARAM_BIT = 6;
  localparam int ST_CHREL_BIT = 5;
  localparam int ST_CODE_MSB = 2;
  // One scanned module status byte
  typedef struct packed {
    logic valid;
    logic [5:0] slot;
    logic [7:0] stat;
  } ddbb_scan_t;
  // Builder states
  typedef enum logic [1:0] {
    DDBB_IDLE = 2'b00,
    DDBB_WALK = 2'b01,
    DDBB_DONE = 2'b10
  } ddbb_state_t;
endpackage

//--- ddbb_top.sv
// Diagnostic block builder: status scan, block assembly, read ports
`timescale 1ns/1ns
`default_nettype none
module ddbb_top #(
  parameter logic [7:0] MASTER_ADDR = 8'hFF, // Reported master address
  parameter logic [15:0] IDENT = 16'hA55A // Arbitrary identity value
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Module status scan
  input wire ddbb_pkg::ddbb_scan_t scan,
  input wire logic [63:0] diag_rel,
  // Block read port
  input wire logic rd_en,
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_vld,
  output logic [6:0] blk_len,
  output logic diag_msg,
  output logic diag_busy,
  // Data set read port
  input wire logic ds_req,
  input wire logic [5:0] ds_num,
  output logic [7:0] ds_data,
  output logic ds_ack
);
  import ddbb_pkg::*;

  logic [7:0] stat_r [0:63]; // Last status byte per slot
  logic [7:0] stat_nxt [0:63];
  logic dirty_r, dirty_nxt; // Released event changed
  logic [7:0] blk_r [0:63]; // Variable part bytes
  logic [7:0] blk_nxt [0:63];
  ddbb_state_t state_r, state_nxt;
  logic [5:0] idx_r, idx_nxt; // Slot under walk
  logic [6:0] wptr_r, wptr_nxt; // Next free byte
  logic [63:0] bmp_r, bmp_nxt; // Work bitmap
  logic ovf_r, ovf_nxt; // Work overflow
  logic [63:0] bmp_pub_r, bmp_pub_nxt; // Published bitmap
  logic ovf_pub_r, ovf_pub_nxt; // Published overflow
  logic [6:0] len_r, len_nxt; // Published length
  logic msg_r, msg_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_vld_r, rd_vld_nxt;
  logic [7:0] ds_data_r, ds_data_nxt;
  logic ds_ack_r, ds_ack_nxt;

  // Scan store and change detection
  always_comb begin
    logic [7:0] old_s;
    old_s = stat_r[scan.slot];
    stat_nxt = stat_r;
    dirty_nxt = dirty_r;
    // Walk start consumes the change
    if (state_r == DDBB_IDLE && dirty_r) begin
      dirty_nxt = 1'b0;
    end
    if (scan.valid) begin
      stat_nxt[scan.slot] = scan.stat;
      // Any change of a released slot that is or was pending, set beats clear
      if (diag_rel[scan.slot] && (old_s != scan.stat) &&
          (old_s[ST_PEND_BIT] || scan.stat[ST_PEND_BIT])) begin
        dirty_nxt = 1'b1;
      end
    end
  end

  // Scan store registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 64; i++) begin
        stat_r[i] <= 8'h00;
      end
      dirty_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      dirty_r <= dirty_nxt;
    end
  end

  // Block assembly walk
  always_comb begin
    logic [7:0] s;
    logic act;
    logic [6:0] need;
    logic [5:0] w;
    s = stat_r[idx_r];
    act = s[ST_PEND_BIT] && diag_rel[idx_r];
    need = s[ST_PARAM_BIT] ? PS_LEN : CH_LEN;
    w = wptr_r[5:0];
    blk_nxt = blk_r;
    state_nxt = state_r;
    idx_nxt = idx_r;
    wptr_nxt = wptr_r;
    bmp_nxt = bmp_r;
    ovf_nxt = ovf_r;
    bmp_pub_nxt = bmp_pub_r;
    ovf_pub_nxt = ovf_pub_r;
    len_nxt = len_r;
    msg_nxt = 1'b0;
    case (state_r)
      DDBB_IDLE: begin
        // Start a fresh block on any released change
        if (dirty_r) begin
          state_nxt = DDBB_WALK;
          idx_nxt = 6'h00;
          wptr_nxt = STATIC_LEN;
          bmp_nxt = 64'h0;
          ovf_nxt = 1'b0;
        end
      end
      DDBB_WALK: begin
        // Slots taken in position order
        if (act) begin
          if (wptr_r + need <= MAX_LEN) begin
            if (s[ST_PARAM_BIT]) begin
              // Parameterization status entry
              blk_nxt[w] = PS_HDR;
              blk_nxt[w + 6'h01] = PS_TYPE;
              blk_nxt[w + 6'h02] = {2'b00, idx_r};
              blk_nxt[w + 6'h03] = PS_DIFF;
              blk_nxt[w + 6'h04] = PS_ERR_BASE | {5'h00, s[ST_CODE_MSB:0]};
            end else begin
              // Channel entry, module or channel related
              blk_nxt[w] = {CH_TAG, idx_r};
              blk_nxt[w + 6'h01] = {CH_IO_TYPE,
                s[ST_CHREL_BIT] ? {3'b000, s[ST_CODE_MSB:0]} : CH_MODULE_ID};
              blk_nxt[w + 6'h02] = CH_ERR;
            end
            wptr_nxt = wptr_r + need;
            bmp_nxt[idx_r] = 1'b1;
          end else begin
            ovf_nxt = 1'b1;
          end
        end
        if (idx_r == 6'h3F) begin
          state_nxt = DDBB_DONE;
        end else begin
          idx_nxt = idx_r + 6'h01;
        end
      end
      DDBB_DONE: begin
        // Publish the finished block
        bmp_pub_nxt = bmp_r;
        ovf_pub_nxt = ovf_r;
        len_nxt = wptr_r;
        msg_nxt = 1'b1;
        state_nxt = DDBB_IDLE;
      end
      default: begin
        state_nxt = DDBB_IDLE;
      end
    endcase
  end

  // Block assembly registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 64; i++) begin
        blk_r[i] <= 8'h00;
      end
      state_r <= DDBB_IDLE;
      idx_r <= 6'h00;
      wptr_r <= STATIC_LEN;
      bmp_r <= 64'h0;
      ovf_r <= 1'b0;
      bmp_pub_r <= 64'h0;
      ovf_pub_r <= 1'b0;
      len_r <= STATIC_LEN;
      msg_r <= 1'b0;
    end else begin
      blk_r <= blk_nxt;
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      wptr_r <= wptr_nxt;
      bmp_r <= bmp_nxt;
      ovf_r <= ovf_nxt;
      bmp_pub_r <= bmp_pub_nxt;
      ovf_pub_r <= ovf_pub_nxt;
      len_r <= len_nxt;
      msg_r <= msg_nxt;
    end
  end

  // Read ports: block bytes and data sets
  always_comb begin
    logic [5:0] a;
    a = rd_addr;
    rd_data_nxt = rd_data_r;
    rd_vld_nxt = rd_en;
    ds_data_nxt = ds_data_r;
    ds_ack_nxt = ds_req;
    if (rd_en) begin
      if ({1'b0, a} >= len_r) begin
        rd_data_nxt = 8'h00; // Past the end
      end else if ({1'b0, a} < STD_LEN) begin
        // Standard diagnostic section
        case (a[2:0])
          3'h0: begin
            // Extended diagnostic flag when any slot bit is set
            rd_data_nxt = 8'h00;
            rd_data_nxt[EXT_DIAG_BIT] = |bmp_pub_r;
          end
          3'h1: rd_data_nxt = STD1_FIXED;
          3'h2: begin
            // Overflow flag of the published block
            rd_data_nxt = 8'h00;
            rd_data_nxt[OVF_BIT] = ovf_pub_r;
          end
          3'h3: rd_data_nxt = MASTER_ADDR;
          3'h4: rd_data_nxt = IDENT[15:8];
          default: rd_data_nxt = IDENT[7:0];
        endcase
      end else if (a == MOD_HDR_POS) begin
        rd_data_nxt = MOD_HDR;
      end else if (a < DEV_POS) begin
        rd_data_nxt = bmp_pub_r[{a[2:0] - BMP_POS[2:0], 3'b000} +: 8];
      end else if (a == DEV_POS) begin
        rd_data_nxt = DEV_HDR;
      end else if (a == DEV_POS + 6'h01) begin
        rd_data_nxt = DEV_TYPE;
      end else if ({1'b0, a} < STATIC_LEN) begin
        rd_data_nxt = 8'h00;
      end else begin
        rd_data_nxt = blk_r[a];
      end
    end
    // Data set holds the module's detail status byte
    if (ds_req) begin
      ds_data_nxt = stat_r[ds_num];
    end
  end

  // Read port registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_r <= 8'h00;
      rd_vld_r <= 1'b0;
      ds_data_r <= 8'h00;
      ds_ack_r <= 1'b0;
    end else begin
      rd_data_r <= rd_data_nxt;
      rd_vld_r <= rd_vld_nxt;
      ds_data_r <= ds_data_nxt;
      ds_ack_r <= ds_ack_nxt;
    end
  end

  // Outputs
  assign rd_data = rd_data_r;
  assign rd_vld = rd_vld_r;
  assign ds_data = ds_data_r;
  assign ds_ack = ds_ack_r;
  assign blk_len = len_r;
  assign diag_msg = msg_r;
  assign diag_busy = (state_r != DDBB_IDLE);
endmodule
`default_nettype wire

//--- ddbb_properties.sv
// Port checker of the diagnostic block builder
`timescale 1ns/1ns
`default_nettype none
module ddbb_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Status scan
  input wire ddbb_pkg::ddbb_scan_t scan,
  input wire logic [63:0] diag_rel,
  // Block read port
  input wire logic rd_en,
  input wire logic [5:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_vld,
  input wire logic [6:0] blk_len,
  input wire logic diag_msg,
  input wire logic diag_busy,
  // Data set port
  input wire logic ds_req,
  input wire logic [5:0] ds_num,
  input wire logic [7:0] ds_data,
  input wire logic ds_ack
);
  import ddbb_pkg::*;
  // One domain, so one clock and one disable
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  rd_answer_a: assert property (rd_vld == $past(rd_en)) else $error("read answer timing");
  ds_answer_a: assert property (ds_ack == $past(ds_req)) else $error("data set answer timing");
  len_range_a: assert property (blk_len >= 7'h16 && blk_len <= 7'h40) else $error("length range");
  len_publish_a: assert property ($changed(blk_len) |-> diag_msg) else $error("length moved");
  hdr_byte_a: assert property (rd_en && rd_addr == 6'h06 |=> rd_data == 8'h49) else $error("header");
  past_end_a: assert property (rd_en && {1'b0, rd_addr} >= blk_len && !diag_busy
    |=> rd_data == 8'h00) else $error("byte past end");
  walk_span_a: assert property ($rose(diag_busy) |-> ##65 diag_msg) else $error("walk length");
  msg_pulse_a: assert property (diag_msg |=> !diag_msg) else $error("message pulse");
  unreleased_quiet_a: assert property (!diag_busy && !diag_msg && scan.valid && !diag_rel[scan.slot]
    && !$past(scan.valid) |=> !diag_busy) else $error("unreleased walk");
  // Main scenarios
  msg_c: cover property (diag_msg);
  hdr_c: cover property (rd_vld && rd_data == 8'h49);
  ds_c: cover property (ds_ack);
endmodule
bind ddbb_top ddbb_properties chk_u (.sys_clk, .rst, .scan, .diag_rel, .rd_en, .rd_addr, .rd_data, .rd_vld,
  .blk_len, .diag_msg, .diag_busy, .ds_req, .ds_num, .ds_data, .ds_ack);
`default_nettype wire

//--- ddbb_master_model.sv
// Master-side model issuing block reads and data set reads
`timescale 1ns/1ns
`default_nettype none
module ddbb_master_model (
  // Clock
  input wire logic sys_clk,
  // Block read port
  output logic rd_en = 1'b0,
  output logic [5:0] rd_addr = 6'h00,
  input wire logic [7:0] rd_data,
  input wire logic rd_vld,
  // Data set port
  output logic ds_req = 1'b0,
  output logic [5:0] ds_num = 6'h00,
  input wire logic [7:0] ds_data,
  input wire logic ds_ack
);
  // One-cycle block read, answer taken in the following cycle
  task automatic rd(input logic [5:0] a, output logic v, output logic [7:0] d);
    @(negedge sys_clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge sys_clk);
    rd_en = 1'b0;
    rd_addr = ~a;
    v = rd_vld;
    d = rd_data;
  endtask
  // Acyclic read naming the data set number
  task automatic ds(input logic [5:0] n, output logic v, output logic [7:0] d);
    @(negedge sys_clk);
    ds_req = 1'b1;
    ds_num = n;
    @(negedge sys_clk);
    ds_req = 1'b0;
    ds_num = ~n;
    v = ds_ack;
    d = ds_data;
  endtask
endmodule
`default_nettype wire

//--- ddbb_tb_top.sv
// Testbench of the diagnostic block builder
`timescale 1ns/1ns
`default_nettype none
module ddbb_tb_top;
  import ddbb_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  ddbb_scan_t scan = '0;
  logic [63:0] diag_rel = '0;
  logic rd_en, rd_vld, diag_msg, diag_busy, ds_req, ds_ack;
  logic [5:0] rd_addr, ds_num;
  logic [7:0] rd_data, ds_data;
  logic [6:0] blk_len;
  int n_mismatch = 0;
  int comparisons = 0;
  always #5 sys_clk = ~sys_clk;
  ddbb_top #(.MASTER_ADDR(8'hFF), .IDENT(16'h0000)) dut_u (.sys_clk, .rst, .scan, .diag_rel, .rd_en, .rd_addr,
    .rd_data, .rd_vld, .blk_len, .diag_msg, .diag_busy, .ds_req, .ds_num, .ds_data, .ds_ack);
  ddbb_master_model m_u (.sys_clk, .rd_en, .rd_addr, .rd_data, .rd_vld, .ds_req, .ds_num, .ds_data, .ds_ack);
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Read one block byte and compare
  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    logic v;
    logic [7:0] d;
    m_u.rd(a, v, d);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask
  // One status byte on the scan
  task automatic scan1(input logic [5:0] s, input logic [7:0] t);
    @(negedge sys_clk);
    scan = '{valid: 1'b1, slot: s, stat: t};
    @(negedge sys_clk);
    scan.valid = 1'b0;
  endtask
  // Wait for the last message of a burst of walks
  task automatic settle();
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 400; i++) begin
      @(negedge sys_clk);
      if (diag_msg === 1'b1) seen = 1'b1;
      else if (seen && diag_busy === 1'b0) break;
    end
    chk({7'h00, seen}, 8'h01);
  endtask
  // Static part after reset
  task automatic t_static();
    logic [7:0] e;
    for (int i = 0; i < 23; i++) begin
      e = (i == 1) ? 8'h04 : (i == 3) ? 8'hFF : (i == 6) ? 8'h49 : (i == 15) ? 8'h07 : (i == 16) ? 8'h81 : 8'h00;
      rdc(6'(i), e);
    end
    chk({1'b0, blk_len}, 8'h16);
  endtask
  // Channel entry, then parameterization entry ahead of it
  task automatic t_entries();
    logic [7:0] ex [8] = '{8'h05, 8'h81, 8'h02, 8'h00, 8'h42, 8'h85, 8'h43, 8'h29};
    logic v;
    logic [7:0] d;
    diag_rel[5] = 1'b1;
    diag_rel[2] = 1'b1;
    scan1(6'h05, 8'hA3);
    settle();
    chk({1'b0, blk_len}, 8'h19);
    rdc(6'h00, 8'h08);
    rdc(6'h07, 8'h20);
    rdc(6'h16, 8'h85);
    rdc(6'h17, 8'h43);
    m_u.ds(6'h05, v, d);
    chk({7'h00, v}, 8'h01);
    chk(d, 8'hA3);
    scan1(6'h02, 8'hC2);
    settle();
    chk({1'b0, blk_len}, 8'h1E);
    for (int i = 0; i < 8; i++) rdc(6'(22 + i), ex[i]);
    rdc(6'h07, 8'h24);
  endtask
  // Unreleased slot, then a clearing event
  task automatic t_quiet_clear();
    int msgs;
    logic v;
    logic [7:0] d;
    msgs = 0;
    scan1(6'h09, 8'h80);
    repeat (80) begin
      @(negedge sys_clk);
      if (diag_msg !== 1'b0) msgs++;
    end
    chk(8'(msgs), 8'h00);
    m_u.ds(6'h09, v, d);
    chk(d, 8'h80);
    scan1(6'h05, 8'h00);
    settle();
    chk({1'b0, blk_len}, 8'h1B);
    rdc(6'h07, 8'h04);
    rdc(6'h1B, 8'h00);
  endtask
  // Module-related channel entry on slot 1, then its clearing
  task automatic t_module_rel();
    diag_rel[1] = 1'b1;
    scan1(6'h01, 8'h84);
    @(negedge sys_clk);
    chk({7'h00, diag_busy}, 8'h01);
    settle();
    chk({1'b0, blk_len}, 8'h1E);
    rdc(6'h07, 8'h06);
    rdc(6'h16, 8'h81);
    rdc(6'h17, 8'h7F);
    rdc(6'h18, 8'h29);
    rdc(6'h19, 8'h05);
    scan1(6'h01, 8'h00);
    settle();
    chk({1'b0, blk_len}, 8'h1B);
    rdc(6'h16, 8'h05);
  endtask
  // Eight more parameterization entries, the last one cannot fit
  task automatic t_overflow();
    diag_rel[17:10] = 8'hFF;
    for (int s = 10; s < 18; s++) begin
      @(negedge sys_clk);
      scan = '{valid: 1'b1, slot: 6'(s), stat: 8'hC0};
    end
    @(negedge sys_clk);
    scan.valid = 1'b0;
    settle();
    chk({1'b0, blk_len}, 8'h3E);
    rdc(6'h02, 8'h80);
    rdc(6'h08, 8'hFC);
    rdc(6'h09, 8'h01);
    rdc(6'h3B, 8'h10);
  endtask
  // Verdict
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, well above the run length
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    t_static();
    t_entries();
    t_quiet_clear();
    t_module_rel();
    t_overflow();
    summarize();
  end
endmodule
`default_nettype wire
